// ==== src/power_stage_waveform_gen.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - A cycle is part A (output a) then part B (output b); ends with B.
// - Four running modes: four-ramp, two-ramp, one-ramp, center-aligned.
// - Four-ramp: separate phases; on-time a = reset A, on-time b = reset B.
// - Four-ramp dead-time is set value plus 2 periods.
// - Two-ramp: dead-time = set plus 1; on-time = reset minus set.
// - One-ramp: one shared ramp; outputs may overlap.
// - Center: down-up count; cycle twice (reset B plus 1).
// - Center mode ignores reset A for output timing.
// - Pending set loads at the end of the last ramp, any mode.
// - Fifty-percent mode uses part B compare values for part A.
// - Buffered values apply together at cycle end while running; reset A applies at once.
// - Auto-hold loads only if reset B was written last.
// - Auto-hold selection change acts after the next cycle end.
// - Hold blocks updates; pending update follows after hold clears.
// - Buffered: output config, matrix, set A, set B, reset B; not reset A.
// - Auto-hold wins over hold when both set.
// - Enhanced mode: frames of 16; divider from reset B bits 15:12.
// - d cycles per frame are one period longer.
// - Extra step is inserted while output a is in its active part.
// - Lengthened positions follow bit-reversed order; position 15 never.
// - Four- and two-ramp cycle length is sum of both on-times and dead-times.
// - Compare values are 12-bit; set A decides when output a rises.
module power_stage_waveform_gen (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Power switch drives
  output logic             drive_out_a,
  output logic             drive_out_b
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 run;
    logic [1:0]           mode;
    logic                 fifty;
    logic                 enh;
    logic                 hold;
    logic                 auto_sel;
    logic                 auto_eff;
    logic [11:0]          sh_sa;
    logic [11:0]          sh_ra;
    logic [11:0]          sh_sb;
    logic [15:0]          sh_rb;
    logic [1:0]           sh_oc;
    logic [3:0]           sh_om;
    logic [11:0]          act_sa;
    logic [11:0]          act_sb;
    logic [15:0]          act_rb;
    logic [1:0]           act_oc;
    logic [3:0]           act_om;
    logic                 pending;
    logic                 rb_last;
    logic [14:0]          cnt;
    logic [3:0]           frame;
    logic                 stalled;
    logic                 dp_wr;
    logic [7:0]           dp_addr;
    logic [31:0]          rdata;
    logic                 out_a;
    logic                 out_b;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic [11:0] eff_sa;
  logic [11:0] eff_ra;
  logic [11:0] eff_sb;
  logic [11:0] eff_rb;
  logic [14:0] a_on;
  logic [14:0] a_off;
  logic [14:0] b_on;
  logic [14:0] b_off;
  logic [14:0] total;
  logic [14:0] pos;
  logic [14:0] stall_at;
  logic [3:0]  rev_frame;
  logic        ext;
  logic        stall;
  logic        cyc_end;
  logic        allow;
  logic        load;
  logic        addr_ph;
  logic        oa;
  logic        ob;
  logic        buf_wr;

  assign hrdata      = s_r.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign drive_out_a = s_r.out_a;
  assign drive_out_b = s_r.out_b;

  // ----------------------------------------------------------------
  // Waveform timing
  // ----------------------------------------------------------------
  always_comb begin
    eff_sa = s_r.fifty ? s_r.act_sb : s_r.act_sa;
    eff_ra = s_r.fifty ? s_r.act_rb[11:0] : s_r.sh_ra;
    eff_sb = s_r.act_sb;
    eff_rb = s_r.act_rb[11:0];
    a_on   = {3'h0, eff_sa} + pwm_gen_pkg::DT_RAMP_EXTRA;
    a_off  = {3'h0, eff_ra} + pwm_gen_pkg::DT_RAMP_EXTRA;
    b_on   = {3'h0, eff_sb} + pwm_gen_pkg::DT_RAMP_EXTRA;
    b_off  = {3'h0, eff_rb} + pwm_gen_pkg::DT_RAMP_EXTRA;
    total  = b_off;
    pos    = 15'h0000;
    case (pwm_gen_pkg::run_mode_e'(s_r.mode))
      pwm_gen_pkg::MODE_FOUR: begin
        a_on  = {3'h0, eff_sa} + pwm_gen_pkg::DT_FOUR_EXTRA;
        a_off = a_on + {3'h0, eff_ra};
        b_on  = a_off + {3'h0, eff_sb} + pwm_gen_pkg::DT_FOUR_EXTRA;
        b_off = b_on + {3'h0, eff_rb};
        total = b_off;
      end
      pwm_gen_pkg::MODE_TWO: begin
        b_on  = a_off + {3'h0, eff_sb} + pwm_gen_pkg::DT_RAMP_EXTRA;
        b_off = b_on + {3'h0, eff_rb} - {3'h0, eff_sb};
        total = b_off;
      end
      pwm_gen_pkg::MODE_ONE: begin
        total = b_off;
      end
      pwm_gen_pkg::MODE_CENTER: begin
        total = {b_off[13:0], 1'b0};
        pos   = (s_r.cnt <= {3'h0, eff_rb}) ? ({3'h0, eff_rb} - s_r.cnt)
                                            : (s_r.cnt - b_off);
      end
      default: begin
        total = b_off;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Enhanced resolution and cycle control
  // ----------------------------------------------------------------
  always_comb begin
    rev_frame = {s_r.frame[0], s_r.frame[1], s_r.frame[2], s_r.frame[3]};
    ext = s_r.enh && (rev_frame < s_r.act_rb[15:12]);
    stall_at = (s_r.mode == 2'(pwm_gen_pkg::MODE_CENTER)) ? {3'h0, eff_rb} : a_on;
    stall = s_r.run && ext && !s_r.stalled && (s_r.cnt == stall_at);
    cyc_end = s_r.run && !stall && (s_r.cnt == total - 15'h0001);
    allow = s_r.auto_eff ? s_r.rb_last : !s_r.hold;
    load = s_r.pending && allow && (cyc_end || !s_r.run);
    if (s_r.mode == 2'(pwm_gen_pkg::MODE_CENTER)) begin
      oa = pos < {3'h0, eff_sa};
      ob = pos >= {3'h0, eff_sb};
    end else begin
      oa = (s_r.cnt >= a_on) && (s_r.cnt < a_off);
      ob = (s_r.cnt >= b_on) && (s_r.cnt < b_off);
    end
    addr_ph = hsel && htrans[1] && hready;
    buf_wr  = s_r.dp_wr && (s_r.dp_addr == pwm_gen_pkg::OFS_SET_A ||
                            s_r.dp_addr == pwm_gen_pkg::OFS_SET_B ||
                            s_r.dp_addr == pwm_gen_pkg::OFS_RESET_B ||
                            s_r.dp_addr == pwm_gen_pkg::OFS_OUT_CFG);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Counter
    if (!s_r.run) begin
      s_nxt.cnt     = 15'h0000;
      s_nxt.stalled = 1'b0;
    end else if (stall) begin
      s_nxt.stalled = 1'b1;
    end else if (cyc_end) begin
      s_nxt.cnt     = 15'h0000;
      s_nxt.stalled = 1'b0;
      s_nxt.frame   = s_r.frame + 4'h1;
      s_nxt.auto_eff = s_r.auto_sel;
    end else begin
      s_nxt.cnt = s_r.cnt + 15'h0001;
    end
    // Outputs
    s_nxt.out_a = s_r.run && s_r.act_oc[0] && oa;
    s_nxt.out_b = s_r.run && s_r.act_oc[1] && ob;
    // Buffered value transfer
    if (load) begin
      s_nxt.act_sa  = s_r.sh_sa;
      s_nxt.act_sb  = s_r.sh_sb;
      s_nxt.act_rb  = s_r.sh_rb;
      s_nxt.act_oc  = s_r.sh_oc;
      s_nxt.act_om  = s_r.sh_om;
      s_nxt.pending = 1'b0;
      s_nxt.rb_last = 1'b0;
    end
    // Bus write data phase
    if (s_r.dp_wr) begin
      case (s_r.dp_addr)
        pwm_gen_pkg::OFS_CTRL: begin
          s_nxt.run      = hwdata[pwm_gen_pkg::CTRL_RUN];
          s_nxt.mode     = hwdata[pwm_gen_pkg::CTRL_MODE_LO +: 2];
          s_nxt.fifty    = hwdata[pwm_gen_pkg::CTRL_FIFTY];
          s_nxt.enh      = hwdata[pwm_gen_pkg::CTRL_ENH];
          s_nxt.hold     = hwdata[pwm_gen_pkg::CTRL_HOLD];
          s_nxt.auto_sel = hwdata[pwm_gen_pkg::CTRL_AUTO];
        end
        pwm_gen_pkg::OFS_SET_A:   s_nxt.sh_sa = hwdata[11:0];
        pwm_gen_pkg::OFS_RESET_A: s_nxt.sh_ra = hwdata[11:0];
        pwm_gen_pkg::OFS_SET_B:   s_nxt.sh_sb = hwdata[11:0];
        pwm_gen_pkg::OFS_RESET_B: s_nxt.sh_rb = hwdata[15:0];
        pwm_gen_pkg::OFS_OUT_CFG: begin
          s_nxt.sh_oc = hwdata[1:0];
          s_nxt.sh_om = hwdata[pwm_gen_pkg::OCFG_MTX_LO +: 4];
        end
        default: begin
        end
      endcase
    end
    if (buf_wr) begin
      s_nxt.pending = 1'b1;
      s_nxt.rb_last = (s_r.dp_addr == pwm_gen_pkg::OFS_RESET_B);
    end
    // Bus address phase and read data
    s_nxt.dp_wr   = addr_ph && hwrite;
    s_nxt.dp_addr = haddr[7:0];
    if (addr_ph && !hwrite) begin
      case (haddr[7:0])
        pwm_gen_pkg::OFS_CTRL: s_nxt.rdata = {25'h0, s_r.auto_sel, s_r.hold, s_r.enh,
                                              s_r.fifty, s_r.mode, s_r.run};
        pwm_gen_pkg::OFS_SET_A:   s_nxt.rdata = {20'h0, s_r.sh_sa};
        pwm_gen_pkg::OFS_RESET_A: s_nxt.rdata = {20'h0, s_r.sh_ra};
        pwm_gen_pkg::OFS_SET_B:   s_nxt.rdata = {20'h0, s_r.sh_sb};
        pwm_gen_pkg::OFS_RESET_B: s_nxt.rdata = {16'h0, s_r.sh_rb};
        pwm_gen_pkg::OFS_OUT_CFG: s_nxt.rdata = {24'h0, s_r.sh_om, 2'h0, s_r.sh_oc};
        pwm_gen_pkg::OFS_STATUS:  s_nxt.rdata = {2'h0, s_r.act_om, s_r.act_oc, s_r.auto_eff,
                                                 s_r.pending, s_r.frame, s_r.out_b,
                                                 s_r.out_a, 1'b0, s_r.cnt};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.sh_oc  <= pwm_gen_pkg::RST_OCFG;
      s_r.act_oc <= pwm_gen_pkg::RST_OCFG;
      s_r.sh_rb  <= pwm_gen_pkg::RST_CMP;
      s_r.act_rb <= pwm_gen_pkg::RST_CMP;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cycle_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    cyc_end |=> s_r.cnt == 15'h0000)
    else $error("counter did not wrap at cycle end");
  chk_no_midload: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.run && !cyc_end) |=> s_r.act_sb == $past(s_r.act_sb))
    else $error("active value changed mid cycle");
  chk_hold_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.hold && !s_r.auto_eff) |=> $stable(s_r.act_rb))
    else $error("update happened under hold");
  chk_auto_rb: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_end && s_r.auto_eff && !s_r.rb_last) |=> $stable(s_r.act_sa))
    else $error("auto-hold loaded without reset B last");
  chk_frame_adv: assert property (@(posedge hclk) disable iff (!hresetn)
    cyc_end |=> s_r.frame == $past(s_r.frame) + 4'h1)
    else $error("frame position did not advance");
  chk_pos_last: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.frame == pwm_gen_pkg::FRAME_LAST) |-> !ext)
    else $error("last frame position lengthened");
  chk_stall_cnt: assert property (@(posedge hclk) disable iff (!hresetn)
    stall |=> $stable(s_r.cnt) ##1 (s_r.cnt != $past(s_r.cnt) || !s_r.run))
    else $error("lengthening step not exactly one period");
  chk_stopped_low: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.run |=> !drive_out_a && !drive_out_b)
    else $error("outputs active while stopped");
  chk_auto_late: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cyc_end && s_r.run) |=> $stable(s_r.auto_eff))
    else $error("auto-hold selection acted before cycle end");

  // ----------------------------------------------------------------
  // Timing and update checks
  // ----------------------------------------------------------------
  chk_out_a_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.act_oc[0] |=> !drive_out_a)
    else $error("output a driven while disabled");
  chk_out_b_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.act_oc[1] |=> !drive_out_b)
    else $error("output b driven while disabled");
  chk_four_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_end && s_r.mode == 2'(pwm_gen_pkg::MODE_FOUR)) |-> s_r.cnt ==
      {3'h0, eff_sa} + {3'h0, eff_ra} + {3'h0, eff_sb} + {3'h0, eff_rb} + 15'h0003)
    else $error("four-ramp cycle length wrong");
  chk_two_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_end && s_r.mode == 2'(pwm_gen_pkg::MODE_TWO)) |->
      s_r.cnt == {3'h0, eff_ra} + {3'h0, eff_rb} + 15'h0001)
    else $error("two-ramp cycle length wrong");
  chk_one_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_end && s_r.mode == 2'(pwm_gen_pkg::MODE_ONE)) |-> s_r.cnt == {3'h0, eff_rb})
    else $error("one-ramp cycle length wrong");
  chk_center_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_end && s_r.mode == 2'(pwm_gen_pkg::MODE_CENTER)) |-> s_r.cnt == {2'h0, eff_rb, 1'b1})
    else $error("center cycle length wrong");
  chk_fifty_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.fifty |-> (eff_sa == s_r.act_sb) && (eff_ra == s_r.act_rb[11:0]))
    else $error("fifty mode not using part b values");
  chk_load_at_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (load && s_r.run) |-> cyc_end)
    else $error("value set loaded away from cycle end");
  chk_pending_set: assert property (@(posedge hclk) disable iff (!hresetn)
    buf_wr |=> s_r.pending)
    else $error("buffered write left no pending update");
  chk_stall_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (stall && s_r.mode != 2'(pwm_gen_pkg::MODE_CENTER) && s_r.act_oc[0] && a_off > a_on) |=>
      drive_out_a && s_r.stalled)
    else $error("extra step outside output a part");
  chk_enh_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.enh |-> !ext)
    else $error("cycle lengthened outside enhanced mode");
  chk_frac_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.act_rb[15:12] == 4'h0) |-> !ext)
    else $error("cycle lengthened with zero divider");
  chk_frac_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.enh && s_r.frame == 4'h0 && s_r.act_rb[15:12] != 4'h0) |-> ext)
    else $error("frame position 0 not lengthened");
  chk_frac_second: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.enh && s_r.frame == 4'h8 && s_r.act_rb[15:12] > 4'h1) |-> ext)
    else $error("frame position 8 not lengthened");
  chk_stop_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.run |=> s_r.cnt == 15'h0000 && !s_r.stalled)
    else $error("counter not cleared while stopped");
  chk_auto_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_end && s_r.auto_eff && s_r.hold && s_r.rb_last && s_r.pending) |=> s_r.act_rb == $past(s_r.sh_rb))
    else $error("hold blocked an auto-hold update");
  chk_hold_free: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_end && !s_r.auto_eff && !s_r.hold && s_r.pending) |=> s_r.act_sb == $past(s_r.sh_sb))
    else $error("pending update missed after hold release");
  chk_center_mid: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.run && s_r.mode == 2'(pwm_gen_pkg::MODE_CENTER) && s_r.act_oc[0] &&
     s_r.cnt == {3'h0, eff_rb} && eff_sa != 12'h000) |=> drive_out_a)
    else $error("output a low at center of cycle");
  chk_two_dead: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.run && s_r.mode == 2'(pwm_gen_pkg::MODE_TWO) && s_r.cnt <= {3'h0, eff_sa}) |=> !drive_out_a)
    else $error("output a active in two-ramp dead time");
  chk_four_dead: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.run && s_r.mode == 2'(pwm_gen_pkg::MODE_FOUR) &&
     s_r.cnt < {3'h0, eff_sa} + 15'h0002) |=> !drive_out_a)
    else $error("output a active in four-ramp dead time");
  chk_rb_last_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    (load && !buf_wr) |=> !s_r.rb_last)
    else $error("reset b marker kept after load");

  cov_center_end: cover property (@(posedge hclk) disable iff (!hresetn)
    cyc_end && s_r.mode == 2'(pwm_gen_pkg::MODE_CENTER));
  cov_enh_stall: cover property (@(posedge hclk) disable iff (!hresetn) stall);
  cov_auto_load: cover property (@(posedge hclk) disable iff (!hresetn)
    load && s_r.auto_eff);
  cov_fifty_end: cover property (@(posedge hclk) disable iff (!hresetn)
    cyc_end && s_r.fifty);
  cov_hold_wait: cover property (@(posedge hclk) disable iff (!hresetn)
    cyc_end && s_r.pending && s_r.hold && !s_r.auto_eff);

endmodule : power_stage_waveform_gen

// ==== src/pwm_gen_pkg.sv ====
package pwm_gen_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SET_A    = 8'h04;
  localparam logic [7:0] OFS_RESET_A  = 8'h08;
  localparam logic [7:0] OFS_SET_B    = 8'h0C;
  localparam logic [7:0] OFS_RESET_B  = 8'h10;
  localparam logic [7:0] OFS_OUT_CFG  = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;

  // ----------------------------------------------------------------
  // Control, reset B and output config field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_MODE_LO  = 1;
  localparam int CTRL_FIFTY    = 3;
  localparam int CTRL_ENH      = 4;
  localparam int CTRL_HOLD     = 5;
  localparam int CTRL_AUTO     = 6;
  localparam int RB_FRAC_LO    = 12;
  localparam int OCFG_MTX_LO   = 4;

  // ----------------------------------------------------------------
  // Widths, reset values and counts
  // ----------------------------------------------------------------
  localparam int CMP_W = 12;
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] DT_FOUR_EXTRA = 15'h0002;
  localparam logic [CNT_W-1:0] DT_RAMP_EXTRA = 15'h0001;
  localparam logic [3:0]       FRAME_LAST    = 4'hF;
  localparam logic [15:0]      RST_CMP       = 16'h0000;
  localparam logic [1:0]       RST_OCFG      = 2'h3;

  // ----------------------------------------------------------------
  // Running modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FOUR,
    MODE_TWO,
    MODE_ONE,
    MODE_CENTER
  } run_mode_e;

endpackage : pwm_gen_pkg

// ==== tb/switch_model.sv ====
`timescale 1ns/10ps
module switch_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Gate drives
  input  wire logic        drive_out_a,
  input  wire logic        drive_out_b,
  // Measured times in clock periods
  output logic      [15:0] width_a,
  output logic      [15:0] width_b,
  output logic      [15:0] period_a
);
  // ----------------------------------------------------------------
  // Pulse meters of the switch pair and period meter of output a
  // ----------------------------------------------------------------
  logic        prev_a_r;
  logic        prev_b_r;
  logic [15:0] cnt_a_r;
  logic [15:0] cnt_b_r;
  logic [15:0] cnt_p_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {prev_a_r, prev_b_r, cnt_a_r, cnt_b_r, cnt_p_r} <= '0;
      {width_a, width_b, period_a} <= '0;
    end else begin
      prev_a_r <= drive_out_a;
      prev_b_r <= drive_out_b;
      cnt_a_r  <= drive_out_a ? cnt_a_r + 16'h0001 : 16'h0000;
      cnt_b_r  <= drive_out_b ? cnt_b_r + 16'h0001 : 16'h0000;
      cnt_p_r  <= (drive_out_a && !prev_a_r) ? 16'h0000 : cnt_p_r + 16'h0001;
      if (prev_a_r && !drive_out_a) width_a <= cnt_a_r;
      if (prev_b_r && !drive_out_b) width_b <= cnt_b_r;
      if (drive_out_a && !prev_a_r) period_a <= cnt_p_r + 16'h0001;
    end
  end
endmodule : switch_model

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
  // ----------------------------------------------------------------
  // Signals, design and switch model
  // ----------------------------------------------------------------
  localparam logic [31:0] FIFTY = 32'h00000001 << pwm_gen_pkg::CTRL_FIFTY;
  localparam logic [31:0] ENH   = 32'h00000001 << pwm_gen_pkg::CTRL_ENH;
  localparam logic [31:0] HOLD  = 32'h00000001 << pwm_gen_pkg::CTRL_HOLD;
  localparam logic [31:0] AUTO  = 32'h00000001 << pwm_gen_pkg::CTRL_AUTO;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, drive_out_a, drive_out_b;
  logic [31:0] haddr, hwdata, hrdata, rd, t0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] width_a, width_b, period_a;
  logic [3:0]  dv [3] = '{4'h0, 4'h1, 4'hF};
  int          mismatches, checked, cyc;

  power_stage_waveform_gen dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .drive_out_a(drive_out_a), .drive_out_b(drive_out_b));
  switch_model sw (
    .hclk(hclk), .hresetn(hresetn), .drive_out_a(drive_out_a),
    .drive_out_b(drive_out_b), .width_a(width_a), .width_b(width_b), .period_a(period_a));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task give_verdict();
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task wait_rises(input int n);
    repeat (n) @(posedge drive_out_a);
    repeat (3) @(posedge hclk);
  endtask : wait_rises

  task start(input pwm_gen_pkg::run_mode_e m, input logic [31:0] f,
             input logic [15:0] sa, input logic [15:0] ra,
             input logic [15:0] sb, input logic [15:0] rb);
    bus(1'b1, pwm_gen_pkg::OFS_CTRL, 32'h00000000);
    repeat (3) @(posedge hclk);
    chk("stopped outputs", 32'h00000000, {30'h0, drive_out_a, drive_out_b});
    bus(1'b1, pwm_gen_pkg::OFS_SET_A, {16'h0000, sa});
    bus(1'b1, pwm_gen_pkg::OFS_RESET_A, {16'h0000, ra});
    bus(1'b1, pwm_gen_pkg::OFS_SET_B, {16'h0000, sb});
    bus(1'b1, pwm_gen_pkg::OFS_RESET_B, {16'h0000, rb});
    bus(1'b1, pwm_gen_pkg::OFS_CTRL, 32'h00000001 | ({30'h0, m} << 1) | f);
    wait_rises(4);
  endtask : start

  task wave(input logic [15:0] wa, input logic [15:0] wb, input logic [15:0] per);
    chk("width_a", {16'h0000, wa}, {16'h0000, width_a});
    chk("width_b", {16'h0000, wb}, {16'h0000, width_b});
    chk("period", {16'h0000, per}, {16'h0000, period_a});
  endtask : wave

  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize      = 3'h2;
    mismatches = 0;
    checked    = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, pwm_gen_pkg::OFS_CTRL, 32'h00000000);
    chk("ctrl reset", 32'h00000000, rd);
    bus(1'b0, pwm_gen_pkg::OFS_OUT_CFG, 32'h00000000);
    chk("out_cfg reset", {30'h0, pwm_gen_pkg::RST_OCFG}, rd);
    bus(1'b0, pwm_gen_pkg::OFS_RESET_B, 32'h00000000);
    chk("reset_b reset", {16'h0000, pwm_gen_pkg::RST_CMP}, rd);
    bus(1'b1, 8'h1C, 32'hFFFFFFFF);
    bus(1'b0, 8'h1C, 32'h00000000);
    chk("unmapped", 32'h00000000, rd);
    bus(1'b1, pwm_gen_pkg::OFS_SET_B, 32'h0000FFFF);
    bus(1'b0, pwm_gen_pkg::OFS_SET_B, 32'h00000000);
    chk("set_b width", 32'h00000FFF, rd);
    chk("hresp", 32'h00000000, {31'h0, hresp});
    start(pwm_gen_pkg::MODE_FOUR, 32'h0, 16'h0, 16'h1, 16'h0, 16'h1);
    wave(16'h1, 16'h1, 16'h6);
    start(pwm_gen_pkg::MODE_FOUR, 32'h0, 16'h1, 16'h3, 16'h0, 16'h2);
    wave(16'h3, 16'h2, 16'hA);
    start(pwm_gen_pkg::MODE_TWO, 32'h0, 16'h1, 16'h4, 16'h2, 16'h5);
    wave(16'h3, 16'h3, 16'hB);
    start(pwm_gen_pkg::MODE_ONE, 32'h0, 16'h1, 16'h4, 16'h5, 16'h8);
    wave(16'h3, 16'h3, 16'h9);
    start(pwm_gen_pkg::MODE_CENTER, 32'h0, 16'h2, 16'h7, 16'h3, 16'h5);
    wave(16'h4, 16'h6, 16'hC);
    start(pwm_gen_pkg::MODE_FOUR, FIFTY, 16'h9, 16'h9, 16'h1, 16'h3);
    wave(16'h3, 16'h3, 16'hC);
    start(pwm_gen_pkg::MODE_FOUR, 32'h0, 16'h1, 16'h3, 16'h0, 16'h2);
    bus(1'b1, pwm_gen_pkg::OFS_CTRL, 32'h00000001 | HOLD);
    bus(1'b1, pwm_gen_pkg::OFS_RESET_B, 32'h00000006);
    wait_rises(4);
    wave(16'h3, 16'h2, 16'hA);
    bus(1'b1, pwm_gen_pkg::OFS_CTRL, 32'h00000001);
    wait_rises(4);
    wave(16'h3, 16'h6, 16'hE);
    bus(1'b1, pwm_gen_pkg::OFS_CTRL, 32'h00000001 | HOLD | AUTO);
    wait_rises(4);
    bus(1'b1, pwm_gen_pkg::OFS_SET_B, 32'h00000004);
    wait_rises(4);
    wave(16'h3, 16'h6, 16'hE);
    bus(1'b1, pwm_gen_pkg::OFS_RESET_B, 32'h00000006);
    wait_rises(4);
    wave(16'h3, 16'h6, 16'h12);
    for (int i = 0; i < 3; i++) begin
      start(pwm_gen_pkg::MODE_FOUR, ENH, 16'h1, 16'h3, 16'h0, {dv[i], 12'h002});
      @(posedge drive_out_a);
      @(negedge hclk);
      t0 = 32'(cyc);
      repeat (16) @(posedge drive_out_a);
      @(negedge hclk);
      chk("frame length", 32'h000000A0 + {28'h0, dv[i]}, 32'(cyc) - t0);
    end
    give_verdict();
  end
endmodule : tb
